// [verilog/brapf_pkg.sv]
// constants for the bridge arbitration, prefetch and error-report registers
`default_nettype none
package brapf_pkg;
  // dword-aligned configuration offsets
  localparam logic [7:0] OFS_ARB     = 8'h40;
  localparam logic [7:0] OFS_RDPF    = 8'h44;
  localparam logic [7:0] OFS_SERRDIS = 8'h64;
  // arbiter group field
  localparam int         ARB_LSB     = 16;
  localparam int         ARB_W       = 10;
  localparam logic [9:0] ARB_RST     = 10'h200;
  // read prefetch control fields
  localparam int         DS_MAX_LSB  = 6;
  localparam int         US_MAX_LSB  = 4;
  localparam int         DS_CL_BIT   = 2;
  localparam int         US_CL_BIT   = 1;
  localparam int         FLUSH_BIT   = 0;
  localparam logic [7:0] RDPF_RST    = 8'h06;
  localparam logic [7:0] RDPF_MASK   = 8'hf7;
  localparam logic [7:0] PF_UNIT_DW  = 8'h10;
  // 64-byte fallback boundary, in dwords
  localparam logic [7:0] CL_DFLT_DW  = 8'h10;
  // error event disable bits
  localparam logic [7:0] SERRDIS_RST  = 8'h00;
  localparam logic [7:0] SERRDIS_MASK = 8'h7e;
  localparam int         EV_PW_PAR   = 1;
  localparam int         EV_PW_ND    = 2;
  localparam int         EV_PW_TA    = 3;
  localparam int         EV_PW_MA    = 4;
  localparam int         EV_DW_ND    = 5;
  localparam int         EV_DR_ND    = 6;
  // non-delivery attempt limit, two to the 24th
  localparam int         ATTEMPT_LIMIT = 16777216;
  localparam int         CNT_W         = 25;
  localparam int         ND_SRCS       = 3;
endpackage
`default_nettype wire

// [verilog/brapf_serr_if.sv]
// carrier of error events and their gating controls
`default_nettype none
interface brapf_serr_if;
  logic [6:1] event_pulse;
  logic [6:1] disable_bits;
  logic       report_enable;
  modport src  (output event_pulse, output disable_bits,
                output report_enable);
  modport gate (input event_pulse, input disable_bits,
                input report_enable);
endinterface
`default_nettype wire

// [verilog/brapf_attempt_cnt.sv]
// failed-attempt counter raising a non-delivery pulse at its limit
`default_nettype none
module brapf_attempt_cnt #(
  parameter int CNT_W = brapf_pkg::CNT_W,
  parameter int LIMIT = brapf_pkg::ATTEMPT_LIMIT
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic attempt_failed,
  input  wire logic attempt_retired,
  output var  logic non_delivery_ff
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             at_last;
  logic             nxt_non_delivery;

  assign at_last = (cnt_ff == LAST);
  // retiring wins: a delivered transaction never reports non-delivery
  assign nxt_non_delivery = attempt_failed && at_last && !attempt_retired;
  assign nxt_cnt = attempt_retired ? '0 :
                   !attempt_failed ? cnt_ff :
                   at_last         ? '0 : cnt_ff + 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff          <= '0;
      non_delivery_ff <= 1'b0;
    end else begin
      cnt_ff          <= nxt_cnt;
      non_delivery_ff <= nxt_non_delivery;
    end
  end

  AST_CNT_FIRE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (attempt_failed && !attempt_retired && cnt_ff == LAST)
      |=> (non_delivery_ff && cnt_ff == '0))
    else $error("limit reached without non-delivery pulse");
endmodule
`default_nettype wire

// [verilog/brapf_serr_gate.sv]
// gates error events onto the primary system error pin
`default_nettype none
module brapf_serr_gate (
  input  wire logic   clk,
  input  wire logic   rst_b,
  brapf_serr_if.gate  sif,
  output var  logic   serr_oe_ff,
  output var  logic   serr_n_ff
);
  logic [6:1] live_events;
  logic       nxt_assert;

  // a disable bit of 1 hides its event; the report enable gates all
  assign live_events = sif.event_pulse & ~sif.disable_bits;
  assign nxt_assert  = sif.report_enable && (|live_events);

  // open drain: only ever pulled low, released otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serr_oe_ff <= 1'b0;
      serr_n_ff  <= 1'b1;
    end else begin
      serr_oe_ff <= nxt_assert;
      serr_n_ff  <= !nxt_assert;
    end
  end

  AST_SERR_RAISE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (sif.report_enable && |(sif.event_pulse & ~sif.disable_bits))
      |=> (serr_oe_ff && !serr_n_ff))
    else $error("unmasked event did not pull the error pin");

  AST_SERR_QUIET: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!sif.report_enable || !(|(sif.event_pulse & ~sif.disable_bits)))
      |=> (!serr_oe_ff && serr_n_ff))
    else $error("error pin pulled without an unmasked event");
endmodule
`default_nettype wire

// [verilog/brapf_top.sv]
// bridge arbitration group, read prefetch and error-report config block
//
// Summary of operation
// - ten group bits: low nine for secondary requests, top bit for bridge.
// - bit 1 puts master in high group, 0 low; reset sets bridge only.
// - downstream prefetch limit code 00..11 selects 16, 32, 48, 64 dwords.
// - upstream prefetch limit uses its own field with the same encoding.
// - downstream line bit 1 prefetches to cache line, else 64 bytes.
// - upstream line bit 1 prefetches to cache line, else 64 bytes.
// - downstream line bit 0 bounds prefetch by downstream count field.
// - upstream line bit 0 bounds prefetch by upstream count field.
// - flush bit 1 and primary posted write discard primary completions.
// - after a flush the next read retry counts as a new request.
// - flush bit 0 keeps normal ordering and discards nothing.
// - event reaches error pin only if undisabled and reporting enabled.
// - posted write data parity error is an event under disable bit 1.
// - posted write undelivered after 2^24 attempts, disable bit 2.
// - target abort delivering posted write, disable bit 3.
// - master abort delivering posted write, disable bit 4.
// - delayed write undelivered after 2^24 attempts, disable bit 5.
// - delayed read without data after 2^24 attempts, disable bit 6.
// - reserved bits read zero and ignore writes.
`default_nettype none
module brapf_top #(
  parameter int ATTEMPT_LIMIT = brapf_pkg::ATTEMPT_LIMIT
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // configuration access
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  PRIMARY_COMMAND_BYTE_ENABLE_N,
  input  wire logic [31:0] CFG_WDATA,
  output var  logic [31:0] CFG_RDATA,
  // context from other configuration registers
  input  wire logic        SYSTEM_ERROR_REPORT_ENABLE,
  input  wire logic [7:0]  CACHE_LINE_SIZE,
  // arbitration
  output var  logic [9:0]  HIGH_PRIO_GROUP,
  // prefetch engines
  output var  logic [7:0]  DS_PREFETCH_MAX_DW,
  output var  logic        DS_PREFETCH_TO_LINE,
  output var  logic [7:0]  US_PREFETCH_MAX_DW,
  output var  logic        US_PREFETCH_TO_LINE,
  input  wire logic        PRIMARY_POSTED_WRITE,
  output var  logic        FLUSH_PRIMARY_COMPLETIONS,
  // error events from the data path
  input  wire logic        PW_PARITY_ERROR,
  input  wire logic        PW_TARGET_ABORT,
  input  wire logic        PW_MASTER_ABORT,
  input  wire logic [2:0]  ATTEMPT_FAILED,
  input  wire logic [2:0]  ATTEMPT_RETIRED,
  // open-drain error pin
  output var  logic        PRIMARY_SYSTEM_ERROR_OUT_N,
  output var  logic        PRIMARY_SYSTEM_ERROR_OE
);

  logic [9:0]  arb_grp_ff;
  logic [9:0]  nxt_arb_grp;
  logic [7:0]  rdpf_ff;
  logic [7:0]  nxt_rdpf;
  logic [7:0]  serrdis_ff;
  logic [7:0]  nxt_serrdis;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic [7:0]  ds_max_ff;
  logic [7:0]  us_max_ff;
  logic        ds_line_ff;
  logic        us_line_ff;
  logic [9:0]  grp_out_ff;
  logic        flush_ff;

  // ---------------------------------------------------------------
  // address decode and byte lanes
  // ---------------------------------------------------------------
  logic [3:0] lane;
  logic       hit_arb;
  logic       hit_rdpf;
  logic       hit_serrdis;
  logic       wr_arb;
  logic       wr_rdpf;
  logic       wr_serrdis;

  assign lane        = ~PRIMARY_COMMAND_BYTE_ENABLE_N;
  assign hit_arb     = (CFG_ADDR[7:2] == brapf_pkg::OFS_ARB[7:2]);
  assign hit_rdpf    = (CFG_ADDR[7:2] == brapf_pkg::OFS_RDPF[7:2]);
  assign hit_serrdis = (CFG_ADDR[7:2] == brapf_pkg::OFS_SERRDIS[7:2]);
  assign wr_arb      = CFG_WR && hit_arb;
  assign wr_rdpf     = CFG_WR && hit_rdpf && lane[0];
  assign wr_serrdis  = CFG_WR && hit_serrdis && lane[0];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // group bits span lanes 2 and 3; bits 31:26 are never stored
  assign nxt_arb_grp[7:0] = (wr_arb && lane[2]) ?
                            CFG_WDATA[23:16] : arb_grp_ff[7:0];
  assign nxt_arb_grp[9:8] = (wr_arb && lane[3]) ?
                            CFG_WDATA[25:24] : arb_grp_ff[9:8];

  assign nxt_rdpf = wr_rdpf ?
                    (CFG_WDATA[7:0] & brapf_pkg::RDPF_MASK) :
                    rdpf_ff;

  assign nxt_serrdis = wr_serrdis ?
                       (CFG_WDATA[7:0] & brapf_pkg::SERRDIS_MASK) :
                       serrdis_ff;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      arb_grp_ff <= brapf_pkg::ARB_RST;
      rdpf_ff    <= brapf_pkg::RDPF_RST;
      serrdis_ff <= brapf_pkg::SERRDIS_RST;
    end else begin
      arb_grp_ff <= nxt_arb_grp;
      rdpf_ff    <= nxt_rdpf;
      serrdis_ff <= nxt_serrdis;
    end
  end

  // ---------------------------------------------------------------
  // register reads: whole dword regardless of byte enables
  // ---------------------------------------------------------------
  logic [31:0] rd_arb;
  logic [31:0] rd_rdpf;
  logic [31:0] rd_serrdis;
  logic [31:0] rd_word;

  // other fields sharing these dwords live elsewhere and read zero here
  assign rd_arb     = {6'h00, arb_grp_ff, 16'h0000};
  assign rd_rdpf    = {24'h000000, rdpf_ff};
  assign rd_serrdis = {24'h000000, serrdis_ff};
  assign rd_word    = hit_arb     ? rd_arb :
                      hit_rdpf    ? rd_rdpf :
                      hit_serrdis ? rd_serrdis : 32'h00000000;
  assign nxt_rdata  = CFG_RD ? rd_word : rdata_ff;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // prefetch limits
  // ---------------------------------------------------------------
  logic [1:0] ds_code;
  logic [1:0] us_code;
  logic [7:0] ds_count_dw;
  logic [7:0] us_count_dw;
  logic [7:0] line_dw;
  logic [7:0] nxt_ds_max;
  logic [7:0] nxt_us_max;

  assign ds_code = rdpf_ff[brapf_pkg::DS_MAX_LSB +: 2];
  assign us_code = rdpf_ff[brapf_pkg::US_MAX_LSB +: 2];
  // code n selects (n + 1) * 16 dwords
  assign ds_count_dw = 8'({6'h00, ds_code} + 8'h01) *
                       brapf_pkg::PF_UNIT_DW;
  assign us_count_dw = 8'({6'h00, us_code} + 8'h01) *
                       brapf_pkg::PF_UNIT_DW;
  // an unprogrammed line size falls back to a 64-byte boundary
  assign line_dw = (CACHE_LINE_SIZE == 8'h00) ?
                   brapf_pkg::CL_DFLT_DW : CACHE_LINE_SIZE;
  assign nxt_ds_max = rdpf_ff[brapf_pkg::DS_CL_BIT] ?
                      line_dw : ds_count_dw;
  assign nxt_us_max = rdpf_ff[brapf_pkg::US_CL_BIT] ?
                      line_dw : us_count_dw;

  // ---------------------------------------------------------------
  // flush on primary posted write
  // ---------------------------------------------------------------
  logic nxt_flush;

  // the engine drops primary completions, so a later retry of the
  // same read finds nothing queued and starts afresh
  assign nxt_flush = rdpf_ff[brapf_pkg::FLUSH_BIT] &&
                     PRIMARY_POSTED_WRITE;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ds_max_ff  <= brapf_pkg::PF_UNIT_DW;
      us_max_ff  <= brapf_pkg::PF_UNIT_DW;
      ds_line_ff <= 1'b0;
      us_line_ff <= 1'b0;
      grp_out_ff <= brapf_pkg::ARB_RST;
      flush_ff   <= 1'b0;
    end else begin
      ds_max_ff  <= nxt_ds_max;
      us_max_ff  <= nxt_us_max;
      ds_line_ff <= rdpf_ff[brapf_pkg::DS_CL_BIT];
      us_line_ff <= rdpf_ff[brapf_pkg::US_CL_BIT];
      grp_out_ff <= arb_grp_ff;
      flush_ff   <= nxt_flush;
    end
  end

  // ---------------------------------------------------------------
  // non-delivery counters and error events
  // ---------------------------------------------------------------
  logic [2:0] nd_fire;

  // index 0 posted write, 1 delayed write, 2 delayed read
  for (genvar g = 0; g < brapf_pkg::ND_SRCS; g++) begin : g_nd
    brapf_attempt_cnt #(
      .CNT_W (brapf_pkg::CNT_W),
      .LIMIT (ATTEMPT_LIMIT)
    ) u_cnt (
      .clk             (CLK),
      .rst_b           (RST_B),
      .attempt_failed  (ATTEMPT_FAILED[g]),
      .attempt_retired (ATTEMPT_RETIRED[g]),
      .non_delivery_ff (nd_fire[g])
    );
  end

  brapf_serr_if sif ();

  assign sif.event_pulse[brapf_pkg::EV_PW_PAR] = PW_PARITY_ERROR;
  assign sif.event_pulse[brapf_pkg::EV_PW_ND]  = nd_fire[0];
  assign sif.event_pulse[brapf_pkg::EV_PW_TA]  = PW_TARGET_ABORT;
  assign sif.event_pulse[brapf_pkg::EV_PW_MA]  = PW_MASTER_ABORT;
  assign sif.event_pulse[brapf_pkg::EV_DW_ND]  = nd_fire[1];
  assign sif.event_pulse[brapf_pkg::EV_DR_ND]  = nd_fire[2];
  assign sif.disable_bits  = serrdis_ff[6:1];
  assign sif.report_enable = SYSTEM_ERROR_REPORT_ENABLE;

  brapf_serr_gate u_serr (
    .clk        (CLK),
    .rst_b      (RST_B),
    .sif        (sif),
    .serr_oe_ff (PRIMARY_SYSTEM_ERROR_OE),
    .serr_n_ff  (PRIMARY_SYSTEM_ERROR_OUT_N)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign CFG_RDATA                 = rdata_ff;
  assign HIGH_PRIO_GROUP           = grp_out_ff;
  assign DS_PREFETCH_MAX_DW        = ds_max_ff;
  assign US_PREFETCH_MAX_DW        = us_max_ff;
  assign DS_PREFETCH_TO_LINE       = ds_line_ff;
  assign US_PREFETCH_TO_LINE       = us_line_ff;
  assign FLUSH_PRIMARY_COMPLETIONS = flush_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_GROUP_RESET: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !$past(RST_B) |-> (arb_grp_ff == 10'h200 && rdpf_ff == 8'h06))
    else $error("group or prefetch register not at reset value");

  AST_GROUP_FOLLOW: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (CFG_WR && hit_arb && lane[2] && lane[3])
      |=> ##1 (HIGH_PRIO_GROUP == $past(CFG_WDATA[25:16], 2)))
    else $error("group output does not follow written bits");

  AST_DS_COUNT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !rdpf_ff[2] |=> (DS_PREFETCH_MAX_DW ==
      8'(({6'h00, $past(rdpf_ff[7:6])} + 8'h01) << 4)))
    else $error("downstream limit does not match its code");

  AST_US_COUNT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!rdpf_ff[1] && rdpf_ff[5:4] == 2'h2) |=> (US_PREFETCH_MAX_DW == 8'h30))
    else $error("upstream code 10 did not give 48 dwords");

  AST_LINE_DFLT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (rdpf_ff[2] && rdpf_ff[1] && CACHE_LINE_SIZE == 8'h00)
      |=> (DS_PREFETCH_MAX_DW == 8'h10 && US_PREFETCH_MAX_DW == 8'h10))
    else $error("unprogrammed line size did not give 64 bytes");

  AST_FLUSH: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (rdpf_ff[0] && PRIMARY_POSTED_WRITE) |=> FLUSH_PRIMARY_COMPLETIONS)
    else $error("posted write with flush set did not flush");

  AST_NO_FLUSH: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !rdpf_ff[0] |=> !FLUSH_PRIMARY_COMPLETIONS)
    else $error("flush raised while flush bit clear");

  AST_RSVD_ZERO: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (CFG_RD && hit_arb) |=>
      (CFG_RDATA[31:26] == 6'h00 && CFG_RDATA[15:0] == 16'h0000))
    else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// [sim/brapf_host.sv]
// host model issuing configuration reads and writes to the block
`default_nettype none
module brapf_host (
  input  wire logic        clk,
  output var  logic        cfg_wr,
  output var  logic        cfg_rd,
  output var  logic [7:0]  cfg_addr,
  output var  logic [3:0]  be_n,
  output var  logic [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    be_n      = 4'hf;
    cfg_wdata = 32'h0;
  end

  // released address and data lines show the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_wr    = 1'b1;
    cfg_addr  = a;
    be_n      = b;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr    = 1'b0;
    cfg_addr  = ~a;
    be_n      = 4'hf;
    cfg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    #1;
    cfg_rd   = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd   = 1'b0;
    cfg_addr = ~a;
    q        = cfg_rdata;
  endtask
endmodule
`default_nettype wire

// [sim/bridge_arb_prefetch_serr_config_tb.sv]
// self-checking bench for the arbitration, prefetch and error config block
`default_nettype none
module bridge_arb_prefetch_serr_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // short limit keeps counter events within a few cycles
  localparam int LIM = 4;
  logic        clk, rst_b, cfg_wr, cfg_rd, serr_en, pw, flush;
  logic        par, ta, ma, ds_line, us_line, serr_n, serr_oe;
  logic [7:0]  cfg_addr, cls, ds_max, us_max;
  logic [3:0]  be_n;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  logic [9:0]  grp;
  logic [2:0]  fail, ret;
  int          err_total, checks;

  always #2.5 clk = ~clk;

  brapf_host brapf_host_i (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .be_n(be_n), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata));

  brapf_top #(.ATTEMPT_LIMIT(LIM)) brapf_top_i (
    .CLK(clk), .RST_B(rst_b), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
    .CFG_ADDR(cfg_addr), .PRIMARY_COMMAND_BYTE_ENABLE_N(be_n),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .SYSTEM_ERROR_REPORT_ENABLE(serr_en), .CACHE_LINE_SIZE(cls),
    .HIGH_PRIO_GROUP(grp), .DS_PREFETCH_MAX_DW(ds_max),
    .DS_PREFETCH_TO_LINE(ds_line), .US_PREFETCH_MAX_DW(us_max),
    .US_PREFETCH_TO_LINE(us_line), .PRIMARY_POSTED_WRITE(pw),
    .FLUSH_PRIMARY_COMPLETIONS(flush), .PW_PARITY_ERROR(par),
    .PW_TARGET_ABORT(ta), .PW_MASTER_ABORT(ma), .ATTEMPT_FAILED(fail),
    .ATTEMPT_RETIRED(ret), .PRIMARY_SYSTEM_ERROR_OUT_N(serr_n),
    .PRIMARY_SYSTEM_ERROR_OE(serr_oe));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    brapf_host_i.rd(a, v);
    chk("config read", exp, v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_pw(input logic exp);
    @(posedge clk);
    #1;
    pw = 1'b1;
    settle(1);
    pw = 1'b0;
    chk("flush pulse", 32'(exp), 32'(flush));
    settle(1);
    chk("flush released", 32'h0, 32'(flush));
  endtask

  // sources 0..2 are direct events, 3..5 the attempt counters
  task automatic ev(input int s, input logic dis, input logic en,
                    input logic rt);
    int          seen;
    int          due;
    int          dbit;
    logic        fire;
    logic [31:0] pin;
    seen = 0;
    due  = (s > 2) ? 2 : 1;
    fire = !dis && en && !rt;
    case (s)
      0: dbit = brapf_pkg::EV_PW_PAR;
      1: dbit = brapf_pkg::EV_PW_TA;
      2: dbit = brapf_pkg::EV_PW_MA;
      3: dbit = brapf_pkg::EV_PW_ND;
      4: dbit = brapf_pkg::EV_DW_ND;
      default: dbit = brapf_pkg::EV_DR_ND;
    endcase
    brapf_host_i.wr(brapf_pkg::OFS_SERRDIS, 4'he,
                    dis ? 32'(1 << dbit) : 32'h0);
    serr_en = en;
    settle(1);
    case (s)
      0: par = 1'b1;
      1: ta = 1'b1;
      2: ma = 1'b1;
      default: fail[s-3] = 1'b1;
    endcase
    if (s > 2) begin
      settle(LIM - 1);
      ret[s-3] = rt;
    end
    for (int i = 1; i <= 4; i++) begin
      settle(1);
      {par, ta, ma, fail, ret} = '0;
      // pair compared against a fixed value so an unknown cannot pass
      pin = (fire && i == due) ? 32'h2 : 32'h1;
      chk("error pin", pin, 32'({serr_oe, serr_n}));
      if (serr_oe === 1'b1)
        seen = seen | (1 << i);
    end
    chk("error pulse cycles", fire ? 32'(1 << due) : 32'h0, 32'(seen));
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    serr_en = 1'b0;
    cls = 8'h00;
    {pw, par, ta, ma, fail, ret} = '0;
    err_total = 0;
    checks = 0;
    settle(20);
    rst_b = 1'b1;
    settle(2);
    chk("group reset", 32'h200, 32'(grp));
    chk("ds max reset", 32'h10, 32'(ds_max));
    chk("us max reset", 32'h10, 32'(us_max));
    rdchk(brapf_pkg::OFS_ARB, 32'h0200_0000);
    rdchk(brapf_pkg::OFS_RDPF, 32'h06);
    rdchk(brapf_pkg::OFS_SERRDIS, 32'h0);
    brapf_host_i.wr(8'h48, 4'h0, 32'hffff_ffff);
    rdchk(8'h48, 32'h0);
    brapf_host_i.wr(brapf_pkg::OFS_ARB, 4'h0, 32'hffff_ffff);
    rdchk(brapf_pkg::OFS_ARB, 32'h03ff_0000);
    chk("group all high", 32'h3ff, 32'(grp));
    brapf_host_i.wr(brapf_pkg::OFS_ARB, 4'hb, 32'h0);
    chk("group lane2", 32'h300, 32'(grp));
    brapf_host_i.wr(brapf_pkg::OFS_ARB, 4'h7, 32'h0);
    chk("group lane3", 32'h000, 32'(grp));
    for (int c = 0; c < 4; c++) begin
      brapf_host_i.wr(brapf_pkg::OFS_RDPF, 4'he,
                      32'((c << 6) | ((3 - c) << 4)));
      settle(1);
      chk("ds max code", 32'(16 * (c + 1)), 32'(ds_max));
      chk("us max code", 32'(16 * (4 - c)), 32'(us_max));
      chk("line modes off", 32'h0, 32'({ds_line, us_line}));
    end
    brapf_host_i.wr(brapf_pkg::OFS_RDPF, 4'he, 32'hff);
    cls = 8'h08;
    settle(2);
    rdchk(brapf_pkg::OFS_RDPF, 32'hf7);
    chk("ds max line", 32'h08, 32'(ds_max));
    chk("us max line", 32'h08, 32'(us_max));
    chk("line modes on", 32'h3, 32'({ds_line, us_line}));
    pulse_pw(1'b1);
    brapf_host_i.wr(brapf_pkg::OFS_RDPF, 4'he, 32'hfe);
    pulse_pw(1'b0);
    brapf_host_i.wr(brapf_pkg::OFS_SERRDIS, 4'h0, 32'hffff_ffff);
    rdchk(brapf_pkg::OFS_SERRDIS, 32'h7e);
    for (int s = 0; s < 6; s++) begin
      ev(s, 1'b0, 1'b1, 1'b0);
      ev(s, 1'b1, 1'b1, 1'b0);
    end
    ev(0, 1'b0, 1'b0, 1'b0);
    ev(5, 1'b0, 1'b1, 1'b1);
    // second reset from a dirty state: group 0, prefetch f6, read data 7e
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    settle(2);
    rst_b = 1'b1;
    settle(2);
    chk("group re-reset", 32'h200, 32'(grp));
    chk("read data re-reset", 32'h0, cfg_rdata);
    rdchk(brapf_pkg::OFS_RDPF, 32'h06);
    rdchk(brapf_pkg::OFS_ARB, 32'h0200_0000);
    results();
  end
endmodule
`default_nettype wire
